// >>> hdl/nsbp_pkg.sv
`default_nettype none
package nsbp_pkg;
  // Timing
  localparam int CLK_MHZ     = 50;
  localparam int POWERUP_NS  = 2000;
  localparam int POWERUP_CYC = (POWERUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PUP_W       = 8;

  // Array geometry
  localparam int ROW_W         = 16;
  localparam int BLK_W         = 9;
  localparam int BLK_LSB       = 6;
  localparam int REMAP_ENTRIES = 10;
  localparam int REMAP_IDX_W   = 4;
  localparam logic [3:0] BP_ALL_FROM = 4'ha;

  // APB register byte offsets
  localparam logic [7:0] ADDR_STATUS   = 8'h00;
  localparam logic [7:0] ADDR_PROTECT  = 8'h04;
  localparam logic [7:0] ADDR_CONFIG   = 8'h08;
  localparam logic [7:0] ADDR_FAIL_ROW = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_MAP_IDX  = 8'h18;
  localparam logic [7:0] ADDR_MAP_DATA = 8'h1c;

  // Status field positions
  localparam int BUSY_BIT_POSITION  = 0;
  localparam int LATCH_BIT_POSITION = 1;
  localparam int EFAIL_BIT          = 2;
  localparam int PFAIL_BIT          = 3;
  localparam int ECC_LSB            = 4;
  localparam int FULL_BIT           = 6;

  // Protect and config field positions, reset values
  localparam int TB_BIT      = 4;
  localparam int ECC_EN_BIT  = 0;
  localparam int CONT_BIT    = 1;
  localparam logic [4:0] PROTECT_RST = 5'h00;
  localparam logic       ECC_EN_RST  = 1'b1;
  localparam logic       CONT_RST    = 1'b0;

  // ECC outcome codes, also the class of one page
  localparam logic [1:0] ECC_CLEAN = 2'h0;
  localparam logic [1:0] ECC_FIXED = 2'h1;
  localparam logic [1:0] ECC_FAIL1 = 2'h2;
  localparam logic [1:0] ECC_FAILN = 2'h3;

  // Interrupt bits
  localparam int IRQ_W    = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_ECC  = 2;
  localparam int IRQ_FULL = 3;

  typedef enum logic [3:0] {
    NSBP_OP_RESET     = 4'h0,
    NSBP_OP_WR_EN     = 4'h1,
    NSBP_OP_WR_DIS    = 4'h2,
    NSBP_OP_RD_STATUS = 4'h3,
    NSBP_OP_JEDEC_ID  = 4'h4,
    NSBP_OP_PAGE_READ = 4'h5,
    NSBP_OP_PROGRAM   = 4'h6,
    NSBP_OP_ERASE     = 4'h7,
    NSBP_OP_REMAP     = 4'h8,
    NSBP_OP_REMAP_OTP = 4'h9,
    NSBP_OP_CONT_READ = 4'ha,
    NSBP_OP_OTP_PROG  = 4'hb,
    NSBP_OP_OTP_LOCK  = 4'hc
  } nsbp_op_t;

  typedef enum logic [1:0] {
    NSBP_ST_POWERUP = 2'b00,
    NSBP_ST_IDLE    = 2'b01,
    NSBP_ST_BUSY    = 2'b10
  } nsbp_state_t;
endpackage
`default_nettype wire

// >>> hdl/nsbp_remap_table.sv
`timescale 1ns/1ps
`default_nettype none
module nsbp_remap_table
  import nsbp_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   wr_en,
  input  wire logic [ROW_W-1:0]       wr_logical,
  input  wire logic [ROW_W-1:0]       wr_phys,
  input  wire logic [REMAP_IDX_W-1:0] rd_index,
  output logic      [ROW_W-1:0]       rd_logical,
  output logic      [ROW_W-1:0]       rd_phys,
  output logic                        full
);
  logic [REMAP_IDX_W-1:0] used_q;
  logic [ROW_W-1:0]       logical_q [REMAP_ENTRIES];
  logic [ROW_W-1:0]       phys_q    [REMAP_ENTRIES];

  assign full = (used_q == REMAP_IDX_W'(REMAP_ENTRIES)); // RULE_02

  // Fill pointer; a write while full is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      used_q <= '0;
    end else if (wr_en && !full) begin // RULE_02
      used_q <= used_q + 1'b1;
    end
  end

  // One entry pairs a bad block with its replacement
  for (genvar i = 0; i < REMAP_ENTRIES; i++) begin : g_entry
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        logical_q[i] <= '0;
        phys_q[i]    <= '0;
      end else if (wr_en && !full && used_q == REMAP_IDX_W'(i)) begin // RULE_01
        logical_q[i] <= wr_logical;
        phys_q[i]    <= wr_phys;
      end
    end
  end

  // Out-of-range index reads as zero
  always_comb begin
    rd_logical = '0;
    rd_phys    = '0;
    if (rd_index < REMAP_IDX_W'(REMAP_ENTRIES)) begin
      rd_logical = logical_q[rd_index];
      rd_phys    = phys_q[rd_index];
    end
  end
endmodule // nsbp_remap_table
`default_nettype wire

// >>> hdl/nsbp_protect_decode.sv
`timescale 1ns/1ps
`default_nettype none
module nsbp_protect_decode
  import nsbp_pkg::*;
(
  input  wire logic             top_bottom_select,
  input  wire logic [3:0]       protect_code,
  input  wire logic [BLK_W-1:0] block,
  output logic                  is_protected
);
  logic [BLK_W:0] span;

  // Code n in 1..9 covers 2^(n-1) blocks at one end of the array
  always_comb begin
    span         = '0;
    is_protected = 1'b0;
    if (protect_code == 4'h0) begin
      is_protected = 1'b0; // RULE_16
    end else if (protect_code >= BP_ALL_FROM) begin
      is_protected = 1'b1; // RULE_16
    end else begin
      span = (BLK_W+1)'(1) << (protect_code - 4'h1);
      if (top_bottom_select) begin
        is_protected = ({1'b0, block} < span); // RULE_15
      end else begin
        is_protected = ({1'b0, block} >= ((BLK_W+1)'(1) << BLK_W) - span); // RULE_15
      end
    end
  end
endmodule // nsbp_protect_decode
`default_nettype wire

// >>> hdl/nsbp_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (RULE_01) Keep up to ten bad-block to replacement-block pairs.
// (RULE_02) Full flag resets low, rises at ten entries, then remaps are refused.
// (RULE_03) ECC field clears on reset; host ignores it with ECC disabled.
// (RULE_04) ECC 00 clean, 01 corrected, 10 one page uncorrectable.
// (RULE_05) ECC 11 means several uncorrectable pages, continuous read only.
// (RULE_06) Continuous read keeps the row of the latest failing page.
// (RULE_07) Fail flags set on failure or on locked, protected or OTP target.
// (RULE_08) Fail flags clear when program or erase starts and on reset.
// (RULE_09) Write-enable latch sits at status bit 1, set by write-enable.
// (RULE_10) Latch clears at power-up and after listed write-type instructions.
// (RULE_11) Busy at status bit 0 during power-up and internal operations.
// (RULE_12) While busy only status read and ID read are taken.
// (RULE_13) Busy clears when the internal operation finishes.
// (RULE_14) Reserved status bits read zero; writes to them do nothing.
// (RULE_15) Codes 1 to 9 protect 1/512 to 1/2, top or bottom anchored.
// (RULE_16) Code 0 protects nothing; codes 10 and up protect everything.
// (RULE_17) Continuous read ECC keeps the worst outcome across all pages.
// (RULE_18) Program or erase touching a protected block is ignored.
// (RULE_19) Status reads never change any flag, even while busy.
module nsbp_top
  import nsbp_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             ins_valid,
  input  wire logic [3:0]       ins_op,
  input  wire logic [ROW_W-1:0] ins_row,
  input  wire logic [ROW_W-1:0] ins_phys,
  output logic                  ins_accept,
  input  wire logic             otp_locked,
  output logic                  op_start,
  output logic      [3:0]       op_code,
  output logic      [ROW_W-1:0] op_row,
  input  wire logic             op_done,
  input  wire logic             op_fail,
  input  wire logic             page_valid,
  input  wire logic [1:0]       page_class,
  input  wire logic [ROW_W-1:0] page_row,
  output logic                  irq
);
  nsbp_state_t      state_q;
  logic [PUP_W-1:0] pup_cnt_q;
  logic             wel_q;
  logic             pfail_q;
  logic             efail_q;
  logic [1:0]       ecc_q;
  logic [ROW_W-1:0] fail_row_q;
  logic [4:0]       protect_q;
  logic             ecc_en_q;
  logic             cont_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [REMAP_IDX_W-1:0] map_idx_q;
  nsbp_op_t         cur_op_q;
  logic             full_q;
  logic             busy;
  logic             take;
  logic             target_prot;
  logic             table_full;
  logic             pe_op;
  logic             blocked;
  logic             launch;
  logic             remap_wr;
  logic [ROW_W-1:0] map_logical;
  logic [ROW_W-1:0] map_phys;
  logic [IRQ_W-1:0] irq_set;
  logic             apb_wr;
  logic             apb_rd;
  logic             mapped;
  logic [31:0]      status_word;

  assign busy = (state_q != NSBP_ST_IDLE); // RULE_11

  // Status and ID reads bypass the busy guard
  assign ins_accept = ins_valid && (!busy || ins_op == NSBP_OP_RD_STATUS ||
                                    ins_op == NSBP_OP_JEDEC_ID); // RULE_12
  assign take = ins_accept;

  assign pe_op = (ins_op == NSBP_OP_PROGRAM) || (ins_op == NSBP_OP_ERASE);

  // A program or erase on a protected block never starts
  assign blocked = (pe_op && target_prot) || // RULE_18
                   (ins_op == NSBP_OP_OTP_PROG && otp_locked) ||
                   ((ins_op == NSBP_OP_REMAP || ins_op == NSBP_OP_REMAP_OTP) &&
                    table_full); // RULE_02

  // Array operations need the latch; reads always launch
  always_comb begin
    launch = 1'b0;
    if (take && !blocked) begin
      case (ins_op)
        NSBP_OP_PAGE_READ, NSBP_OP_CONT_READ: launch = 1'b1;
        NSBP_OP_PROGRAM, NSBP_OP_ERASE, NSBP_OP_REMAP, NSBP_OP_REMAP_OTP,
        NSBP_OP_OTP_PROG, NSBP_OP_OTP_LOCK: launch = wel_q;
        default: launch = 1'b0;
      endcase
    end
  end

  assign remap_wr = launch &&
                    (ins_op == NSBP_OP_REMAP || ins_op == NSBP_OP_REMAP_OTP); // RULE_01

  nsbp_protect_decode u_protect (
    .top_bottom_select (protect_q[TB_BIT]),
    .protect_code      (protect_q[3:0]),
    .block             (ins_row[BLK_LSB +: BLK_W]),
    .is_protected      (target_prot)
  );

  nsbp_remap_table u_remap (
    .pclk       (pclk),
    .presetn    (presetn),
    .wr_en      (remap_wr),
    .wr_logical (ins_row),
    .wr_phys    (ins_phys),
    .rd_index   (map_idx_q),
    .rd_logical (map_logical),
    .rd_phys    (map_phys),
    .full       (table_full)
  );

  // Busy sequencer: power-up hold, then one operation at a time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= NSBP_ST_POWERUP;
      pup_cnt_q <= '0;
    end else begin
      case (state_q)
        NSBP_ST_POWERUP: begin
          pup_cnt_q <= pup_cnt_q + 1'b1;
          if (pup_cnt_q == PUP_W'(POWERUP_CYC - 1)) begin
            state_q <= NSBP_ST_IDLE; // RULE_11
          end
        end
        NSBP_ST_IDLE: begin
          if (launch) begin
            state_q <= NSBP_ST_BUSY; // RULE_11
          end
        end
        NSBP_ST_BUSY: begin
          if (op_done) begin
            state_q <= NSBP_ST_IDLE; // RULE_13
          end
        end
        default: state_q <= NSBP_ST_IDLE;
      endcase
    end
  end

  // Operation handed to the array engine, one-cycle start pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_start <= 1'b0;
      op_code  <= NSBP_OP_RESET;
      op_row   <= '0;
      cur_op_q <= NSBP_OP_RESET;
    end else begin
      op_start <= launch;
      if (launch) begin
        op_code  <= ins_op;
        op_row   <= ins_row;
        cur_op_q <= nsbp_op_t'(ins_op);
      end
    end
  end

  // Write-enable latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wel_q <= 1'b0; // RULE_10
    end else if (take) begin
      case (ins_op)
        NSBP_OP_WR_EN: wel_q <= 1'b1; // RULE_09
        NSBP_OP_WR_DIS, NSBP_OP_PROGRAM, NSBP_OP_ERASE,
        NSBP_OP_PAGE_READ, NSBP_OP_REMAP_OTP: wel_q <= 1'b0; // RULE_10
        default: wel_q <= wel_q;
      endcase
    end
  end

  // Fail flags: a set in the same cycle as a clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pfail_q <= 1'b0;
      efail_q <= 1'b0;
    end else begin
      if (take && (pe_op || ins_op == NSBP_OP_RESET)) begin
        pfail_q <= 1'b0; // RULE_08
        efail_q <= 1'b0; // RULE_08
      end
      if (take && blocked && (ins_op == NSBP_OP_PROGRAM ||
                              ins_op == NSBP_OP_OTP_PROG)) begin
        pfail_q <= 1'b1; // RULE_07
      end
      if (take && blocked && ins_op == NSBP_OP_ERASE) begin
        efail_q <= 1'b1; // RULE_07
      end
      if (state_q == NSBP_ST_BUSY && op_done && op_fail) begin
        if (cur_op_q == NSBP_OP_ERASE) begin
          efail_q <= 1'b1; // RULE_07
        end else if (cur_op_q == NSBP_OP_PROGRAM || cur_op_q == NSBP_OP_OTP_PROG) begin
          pfail_q <= 1'b1; // RULE_07
        end
      end
    end
  end

  // Cumulative ECC outcome; worst case wins across pages
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ecc_q      <= ECC_CLEAN; // RULE_03
      fail_row_q <= '0;
    end else if (take && ins_op == NSBP_OP_RESET) begin
      ecc_q <= ECC_CLEAN; // RULE_03
    end else if (launch && (ins_op == NSBP_OP_PAGE_READ ||
                            ins_op == NSBP_OP_CONT_READ)) begin
      ecc_q <= ECC_CLEAN;
    end else if (page_valid && ecc_en_q) begin
      if (page_class == ECC_FAIL1 || page_class == ECC_FAILN) begin
        if (cont_q) begin
          fail_row_q <= page_row; // RULE_06
        end
        if (cont_q && ecc_q[1]) begin
          ecc_q <= ECC_FAILN; // RULE_05
        end else if (!ecc_q[1]) begin
          ecc_q <= ECC_FAIL1; // RULE_04
        end
      end else if (page_class == ECC_FIXED && ecc_q == ECC_CLEAN) begin
        ecc_q <= ECC_FIXED; // RULE_17
      end
    end
  end

  // Remembers the full flag to catch its rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_q <= 1'b0;
    end else begin
      full_q <= table_full;
    end
  end

  // Interrupt sources
  always_comb begin
    irq_set           = '0;
    irq_set[IRQ_DONE] = (state_q == NSBP_ST_BUSY) && op_done;
    irq_set[IRQ_FAIL] = ((state_q == NSBP_ST_BUSY) && op_done && op_fail) ||
                        (take && blocked && (pe_op || ins_op == NSBP_OP_OTP_PROG));
    irq_set[IRQ_ECC]  = page_valid && ecc_en_q && page_class[1];
    irq_set[IRQ_FULL] = table_full && !full_q;
  end

  // APB decode; zero wait states, access phase completes at once
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  always_comb begin
    case (paddr)
      ADDR_STATUS, ADDR_PROTECT, ADDR_CONFIG, ADDR_FAIL_ROW,
      ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_MAP_IDX, ADDR_MAP_DATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  // Sticky status: write one to clear, a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else if (apb_wr && paddr == ADDR_IRQ_STAT && pstrb[0]) begin
      irq_stat_q <= (irq_stat_q & ~pwdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_q <= irq_stat_q | irq_set;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Software-written controls; only the low byte holds fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_q  <= PROTECT_RST;
      ecc_en_q   <= ECC_EN_RST;
      cont_q     <= CONT_RST;
      irq_mask_q <= '0;
      map_idx_q  <= '0;
    end else if (apb_wr && pstrb[0]) begin
      case (paddr)
        ADDR_PROTECT:  protect_q  <= pwdata[4:0]; // RULE_14
        ADDR_CONFIG: begin
          ecc_en_q <= pwdata[ECC_EN_BIT];
          cont_q   <= pwdata[CONT_BIT];
        end
        ADDR_IRQ_MASK: irq_mask_q <= pwdata[IRQ_W-1:0];
        ADDR_MAP_IDX:  map_idx_q  <= pwdata[REMAP_IDX_W-1:0];
        default: map_idx_q <= map_idx_q;
      endcase
    end
  end

  // Status word; reserved bits read zero
  always_comb begin
    status_word                         = '0;
    status_word[BUSY_BIT_POSITION]      = busy; // RULE_11
    status_word[LATCH_BIT_POSITION]     = wel_q; // RULE_09
    status_word[EFAIL_BIT]              = efail_q;
    status_word[PFAIL_BIT]              = pfail_q;
    status_word[ECC_LSB +: 2]           = ecc_q;
    status_word[FULL_BIT]               = table_full; // RULE_02
  end

  // Read data captured in the setup cycle; reads have no side effects
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (apb_rd) begin
      case (paddr)
        ADDR_STATUS:   prdata <= status_word; // RULE_19
        ADDR_PROTECT:  prdata <= {27'h0000000, protect_q};
        ADDR_CONFIG:   prdata <= {30'h00000000, cont_q, ecc_en_q};
        ADDR_FAIL_ROW: prdata <= {16'h0000, fail_row_q}; // RULE_06
        ADDR_IRQ_STAT: prdata <= {28'h0000000, irq_stat_q};
        ADDR_IRQ_MASK: prdata <= {28'h0000000, irq_mask_q};
        ADDR_MAP_IDX:  prdata <= {28'h0000000, map_idx_q};
        ADDR_MAP_DATA: prdata <= {map_phys, map_logical};
        default:       prdata <= '0;
      endcase
    end
  end
endmodule // nsbp_top
`default_nettype wire

// >>> verification/nsbp_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module nsbp_engine_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       op_start,
  input  wire logic [7:0] delay,
  input  wire logic       fail_cmd,
  output logic            op_done,
  output logic            op_fail
);
  logic [7:0] cnt_q;
  logic       run_q;
  // One job at a time, ended after the commanded number of cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
    end else if (op_start) begin
      run_q <= 1'b1;
      cnt_q <= delay;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end else begin
      run_q <= 1'b0;
    end
  end
  // Fail is junk outside the done pulse, so the design must qualify it
  assign op_done = run_q && cnt_q == 8'h00;
  assign op_fail = op_done ? fail_cmd : ~fail_cmd;
endmodule // nsbp_engine_model
`default_nettype wire

// >>> verification/nsbp_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module nsbp_top_sva
  import nsbp_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        ins_valid,
  input wire logic [3:0]  ins_op,
  input wire logic [ROW_W-1:0] ins_row,
  input wire logic [ROW_W-1:0] op_row,
  input wire logic        ins_accept,
  input wire logic        op_start,
  input wire logic [3:0]  op_code,
  input wire logic        op_done,
  input wire logic        page_valid,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic run_q;
  logic light;
  // Job in flight from start pulse to done pulse; misses the start cycle on purpose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_q <= 1'b0;
    else run_q <= op_start | (run_q & ~op_done);
  end
  // Instructions allowed past a busy device
  assign light = ins_op == NSBP_OP_RD_STATUS || ins_op == NSBP_OP_JEDEC_ID;
  sequence s_stat_rd;
    psel && penable && !pwrite && paddr == ADDR_STATUS;
  endsequence
  sequence s_job_rd;
    run_q ##0 s_stat_rd;
  endsequence
  property p_busy_refuse;
    run_q && ins_valid && !light |-> !ins_accept;
  endproperty
  property p_status_pass;
    ins_valid && ins_op == NSBP_OP_RD_STATUS |-> ins_accept;
  endproperty
  property p_start_cause;
    op_start |-> $past(ins_accept) && op_code == $past(ins_op) && op_row == $past(ins_row);
  endproperty
  property p_one_job;
    run_q |-> !op_start;
  endproperty
  property p_busy_shown;
    s_job_rd |-> prdata[BUSY_BIT_POSITION];
  endproperty
  property p_start_clears;
    s_job_rd ##0 (op_code == NSBP_OP_PROGRAM || op_code == NSBP_OP_ERASE)
      |-> prdata[PFAIL_BIT:LATCH_BIT_POSITION] == 3'h0;
  endproperty
  property p_reserved_zero;
    s_stat_rd |-> prdata[31:7] == 25'h0;
  endproperty
  property p_read_quiet;
    psel && !pwrite && !op_done && !page_valid |=> $stable(irq);
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("taken while busy");
  a_status_pass: assert property (p_status_pass) else $error("status read refused");
  a_start_cause: assert property (p_start_cause) else $error("bad start");
  a_one_job: assert property (p_one_job) else $error("second job started");
  a_busy_shown: assert property (p_busy_shown) else $error("busy not shown");
  a_start_clears: assert property (p_start_clears) else $error("flags kept");
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved set");
  a_read_quiet: assert property (p_read_quiet) else $error("read changed irq");
endmodule // nsbp_top_sva
bind nsbp_top nsbp_top_sva nsbp_top_sva_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .ins_valid, .ins_op, .ins_row, .op_row, .ins_accept, .op_start, .op_code,
  .op_done, .page_valid, .irq);
`default_nettype wire

// >>> verification/test_nsbp_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_nsbp_top;
  import nsbp_pkg::*;
  logic        pclk, presetn, pready, pslverr, ins_accept, op_start, op_done, op_fail, irq;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ins_valid = 1'b0;
  logic        page_valid = 1'b0, fail_cmd = 1'b0, otp_lk = 1'b0, acc, serr;
  logic [7:0]  paddr = 8'h00, dly = 8'h08;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  ins_op = 4'h0;
  logic [1:0]  page_class = 2'h0;
  logic [15:0] ins_row = 16'h0, ins_phys = 16'h0, page_row = 16'h0;
  logic [21:0] tbl [15];
  int          error_cnt, num_checks, starts, base;
  nsbp_top nsbp_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .ins_valid, .ins_op, .ins_row, .ins_phys,
    .ins_accept, .otp_locked(otp_lk), .op_start, .op_code(), .op_row(), .op_done, .op_fail,
    .page_valid, .page_class, .page_row, .irq);
  nsbp_engine_model nsbp_engine_model_i (.pclk, .presetn, .op_start, .delay(dly),
    .fail_cmd, .op_done, .op_fail);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Launches seen, so blocked instructions can be told from launched ones
  always @(posedge pclk) if (op_start === 1'b1) starts++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; read data and error taken at the pready edge only
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic irqc(input logic e);
    #1;
    chk(32'(irq), 32'(e));
  endtask
  task automatic ins(input logic [3:0] op, input logic [15:0] row);
    @(posedge pclk);
    ins_valid <= 1'b1;
    ins_op <= op;
    ins_row <= row;
    ins_phys <= row + 16'h0100;
    @(posedge pclk);
    acc = ins_accept;
    ins_valid <= 1'b0;
    ins_op <= ~op;
  endtask
  task automatic page(input logic [1:0] c, input logic [15:0] r);
    @(posedge pclk);
    page_valid <= 1'b1;
    page_class <= c;
    page_row <= r;
    @(posedge pclk);
    page_valid <= 1'b0;
    page_class <= ~c;
    page_row <= ~r;
  endtask
  // Poll status until busy drops; a stuck busy shows as a mismatch
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rd[BUSY_BIT_POSITION] !== 1'b0 && n < 300);
    if (n >= 300) chk(rd & 32'h1, 32'h0);
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Whole run is several hundred cycles; 40000 leaves wide margin
  initial begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    // {top_bottom_select, code, protected, row}
    tbl = '{22'h037fc0, 22'h027f80, 22'h23003f, 22'h220040, 22'h134000, 22'h123fc0,
            22'h333fc0, 22'h324000, 22'h2b03ff, 22'h2a0400, 22'h200000, 22'h007fff,
            22'h150000, 22'h172000, 22'h397fff};
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_STATUS, 32'h1);
    ins(NSBP_OP_WR_EN, 16'h0);
    chk(32'(acc), 32'h0);
    ins(NSBP_OP_RD_STATUS, 16'h0);
    chk(32'(acc), 32'h1);
    ins(NSBP_OP_JEDEC_ID, 16'h0);
    chk(32'(acc), 32'h1);
    idle();
    rdc(ADDR_STATUS, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'hffffffff);
    rdc(ADDR_STATUS, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({serr, rd[30:0]}, 32'h80000000);
    apb(1'b1, ADDR_IRQ_MASK, 32'hf);
    ins(NSBP_OP_WR_EN, 16'h0);
    rdc(ADDR_STATUS, 32'h2);
    ins(NSBP_OP_WR_DIS, 16'h0);
    rdc(ADDR_STATUS, 32'h0);
    ins(NSBP_OP_WR_EN, 16'h0);
    ins(NSBP_OP_PROGRAM, 16'h0100);
    rdc(ADDR_STATUS, 32'h1);
    ins(NSBP_OP_WR_EN, 16'h0);
    chk(32'(acc), 32'h0);
    idle();
    chk(rd, 32'h0);
    irqc(1'b1);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    irqc(1'b0);
    apb(1'b1, ADDR_IRQ_MASK, 32'hf);
    rdc(ADDR_IRQ_STAT, 32'h1);
    apb(1'b1, ADDR_IRQ_STAT, 32'hf);
    irqc(1'b0);
    fail_cmd = 1'b1;
    ins(NSBP_OP_WR_EN, 16'h0);
    ins(NSBP_OP_ERASE, 16'h0200);
    idle();
    chk(rd, 32'h4);
    fail_cmd = 1'b0;
    // Each program runs against a freshly set protected range
    foreach (tbl[k]) begin
      apb(1'b1, ADDR_PROTECT, 32'(tbl[k][21:17]));
      base = starts;
      ins(NSBP_OP_WR_EN, 16'h0);
      ins(NSBP_OP_PROGRAM, tbl[k][15:0]);
      idle();
      chk(rd, tbl[k][16] ? 32'h8 : 32'h0);
      chk(32'(starts - base), 32'(!tbl[k][16]));
    end
    rdc(ADDR_PROTECT, 32'h1c);
    apb(1'b1, ADDR_PROTECT, 32'h0);
    dly = 8'h28;
    apb(1'b1, ADDR_CONFIG, 32'h3);
    ins(NSBP_OP_CONT_READ, 16'h0);
    page(ECC_FIXED, 16'h0011);
    page(ECC_FAIL1, 16'h0123);
    page(ECC_FAIL1, 16'h0456);
    page(ECC_CLEAN, 16'h0457);
    idle();
    chk(rd, 32'h38);
    rdc(ADDR_FAIL_ROW, 32'h0456);
    apb(1'b1, ADDR_CONFIG, 32'h1);
    ins(NSBP_OP_PAGE_READ, 16'h0040);
    page(ECC_FIXED, 16'h0040);
    page(ECC_FAIL1, 16'h0789);
    idle();
    chk(rd, 32'h28);
    rdc(ADDR_FAIL_ROW, 32'h0456);
    ins(NSBP_OP_PAGE_READ, 16'h0080);
    page(ECC_FIXED, 16'h0080);
    idle();
    chk(rd, 32'h18);
    ins(NSBP_OP_RESET, 16'h0);
    idle();
    chk(rd, 32'h0);
    dly = 8'h02;
    // Locked one-time area: program refused and flagged, latch kept
    otp_lk <= 1'b1;
    ins(NSBP_OP_WR_EN, 16'h0);
    ins(NSBP_OP_OTP_PROG, 16'h0);
    rdc(ADDR_STATUS, 32'ha);
    ins(NSBP_OP_OTP_LOCK, 16'h0);
    rdc(ADDR_STATUS, 32'hb);
    idle();
    chk(rd, 32'ha);
    for (int i = 0; i < 10; i++) begin
      ins(NSBP_OP_WR_EN, 16'h0);
      ins(i == 9 ? NSBP_OP_REMAP_OTP : NSBP_OP_REMAP, 16'(i + 1));
      idle();
      chk(32'(rd[FULL_BIT]), 32'(i == 9));
      chk(32'(rd[LATCH_BIT_POSITION]), 32'(i != 9));
    end
    apb(1'b1, ADDR_MAP_IDX, 32'h9);
    rdc(ADDR_MAP_DATA, 32'h010a000a);
    base = starts;
    ins(NSBP_OP_WR_EN, 16'h0);
    ins(NSBP_OP_REMAP, 16'h000b);
    idle();
    chk(32'(starts - base), 32'h0);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(rd & 32'h8, 32'h8);
    wrap_up();
  end
endmodule // test_nsbp_top
`default_nettype wire
